/* File: core/dss_top.sv */
// Startup sequencer for a dual-channel switching regulator
`timescale 1ns/100ps
module dss_top #(
  parameter int DELAY_CYC = dss_pkg::SLAVE_DELAY_CYC,
  parameter int OSC_DIV   = dss_pkg::OSC_DIV_DEFAULT
) (
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic SUPPLY_GOOD,
  input  wire logic BIAS_GOOD,
  input  wire logic OUT1_IN_REG,
  input  wire logic OUT2_IN_REG,
  input  wire logic OUTPUT1_ENABLE_N,
  input  wire logic OUTPUT2_ENABLE_N,
  input  wire logic ORDER_SEL_HIGH,
  input  wire logic ORDER_SEL_LOW,
  output logic      BIAS_REG_ON,
  output logic      PWM_ENABLE,
  output logic      SS1_START,
  output logic      SS2_START,
  output logic      RATIO_SS,
  output logic      SW1_PULSE,
  output logic      SW2_PULSE,
  output logic      MODE_VALID
);
  initial begin
    if (DELAY_CYC < 1) $error("DELAY_CYC must be at least 1");
  end

  localparam int DW = $clog2(DELAY_CYC + 1);

  // Reset release through two flops
  logic rst_s1;
  logic rst_n_i;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1  <= 1'b0;
      rst_n_i <= 1'b0;
    end else begin
      rst_s1  <= 1'b1;
      rst_n_i <= rst_s1;
    end
  end

  // Pin-side inputs pass two flops; flags are synchronous per R15 but
  // share the same stage so that all inputs line up in time
  localparam int NS = 8;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  wire  [NS-1:0] raw = {SUPPLY_GOOD, BIAS_GOOD, OUT1_IN_REG,
                        OUT2_IN_REG, OUTPUT1_ENABLE_N, OUTPUT2_ENABLE_N,
                        ORDER_SEL_HIGH, ORDER_SEL_LOW};
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1; // R15
    end
  end

  wire supply_ok = sync2[7];
  wire bias_ok   = sync2[6];
  wire reg1      = sync2[5];
  wire reg2      = sync2[4];
  wire en1       = ~sync2[3];
  wire en2       = ~sync2[2];
  wire [1:0] sel = sync2[1:0];

  // Mode latch: captured once at first supply-good after reset
  dss_pkg::dss_mode_type mode;
  logic                  mode_set;
  wire  take_mode = supply_ok & ~mode_set;
  dss_pkg::dss_mode_type next_mode;
  assign next_mode = (sel == dss_pkg::SEL_HIGH) ? dss_pkg::DSS_MODE_2_FIRST
                   : (sel == dss_pkg::SEL_LOW)  ? dss_pkg::DSS_MODE_1_FIRST
                   : dss_pkg::DSS_MODE_INDEP;
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode     <= dss_pkg::DSS_MODE_INDEP;
      mode_set <= 1'b0;
    end else if (take_mode) begin
      mode     <= next_mode; // R13
      mode_set <= 1'b1;      // R13
    end
  end

  // Master/slave selection by mode
  wire seq_mode    = (mode != dss_pkg::DSS_MODE_INDEP);
  wire two_leads   = (mode == dss_pkg::DSS_MODE_2_FIRST);
  wire master_en   = two_leads ? en2 : en1;
  wire master_reg  = two_leads ? reg2 : reg1;
  wire any_en      = seq_mode ? (master_en | (two_leads ? en1 : en2))
                              : (en1 | en2);
  // In sequential modes the slave enable is assumed held low by the
  // system; only the master enable decides on/off here
  wire seq_go      = master_en; // R04

  // Main sequencing state
  dss_pkg::dss_state_type state;
  dss_pkg::dss_state_type next_state;
  always_comb begin
    next_state = state;
    case (state)
      dss_pkg::DSS_OFF: begin
        if (supply_ok && mode_set) begin
          next_state = dss_pkg::DSS_SHUTDOWN;
        end
      end
      dss_pkg::DSS_SHUTDOWN: begin
        if (any_en) begin
          next_state = dss_pkg::DSS_BIAS_UP; // R10
        end
      end
      dss_pkg::DSS_BIAS_UP: begin
        if (!any_en) begin
          next_state = dss_pkg::DSS_SHUTDOWN; // R14
        end else if (bias_ok) begin
          next_state = dss_pkg::DSS_RUN; // R11
        end
      end
      dss_pkg::DSS_RUN: begin
        if (!any_en) begin
          next_state = dss_pkg::DSS_SHUTDOWN; // R14
        end else if (!bias_ok) begin
          next_state = dss_pkg::DSS_BIAS_UP;
        end
      end
      default: begin
        next_state = dss_pkg::DSS_OFF;
      end
    endcase
    if (!supply_ok) begin
      next_state = dss_pkg::DSS_OFF; // R09
    end
  end

  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= dss_pkg::DSS_OFF;
    end else begin
      state <= next_state;
    end
  end

  wire running = (state == dss_pkg::DSS_RUN);

  // Slave delay counter: restarts whenever master leaves regulation
  logic [DW-1:0] dly;
  wire  dly_done = (dly == DW'(DELAY_CYC));
  wire  master_on = running & seq_mode & seq_go;
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dly <= '0;
    end else if (!(master_on && master_reg)) begin
      dly <= '0;
    end else if (!dly_done) begin
      dly <= dly + 1'b1; // R12
    end
  end

  // Slave release latches once granted, so a later dip in the master's
  // regulation flag does not chop the slave's soft start
  logic slave_rel;
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slave_rel <= 1'b0;
    end else if (!master_on) begin
      slave_rel <= 1'b0; // R02
    end else if (dly_done) begin
      slave_rel <= 1'b1; // R01 R03 R12
    end
  end

  // Per-channel start decisions
  logic next_ss1;
  logic next_ss2;
  always_comb begin
    next_ss1 = 1'b0;
    next_ss2 = 1'b0;
    case (mode)
      dss_pkg::DSS_MODE_2_FIRST: begin
        next_ss2 = master_on;             // R01 R02
        next_ss1 = master_on & slave_rel; // R01 R02
      end
      dss_pkg::DSS_MODE_1_FIRST: begin
        next_ss1 = master_on;             // R03 R02
        next_ss2 = master_on & slave_rel; // R03 R02
      end
      default: begin
        next_ss1 = running & en1; // R05 R06
        next_ss2 = running & en2; // R05 R06
      end
    endcase
  end

  // Ratiometric when both enables rose together in independent mode
  wire  both_now  = en1 & en2;
  wire  ratio_now = (mode == dss_pkg::DSS_MODE_INDEP) & both_now;

  // Channel slots from the oscillator divider
  wire tick1;
  wire tick2;
  dss_phase #(
    .DIV   (OSC_DIV)
  ) u_phase (
    .clk   (CLK),
    .rst_n (rst_n_i),
    .run   (running),
    .tick1 (tick1),
    .tick2 (tick2)
  );

  // Registered outputs; all but RATIO_SS and MODE_VALID forced low under lockout
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      BIAS_REG_ON <= 1'b0;
      PWM_ENABLE  <= 1'b0;
      SS1_START   <= 1'b0;
      SS2_START   <= 1'b0;
      RATIO_SS    <= 1'b0;
      SW1_PULSE   <= 1'b0;
      SW2_PULSE   <= 1'b0;
      MODE_VALID  <= 1'b0;
    end else begin
      BIAS_REG_ON <= (next_state == dss_pkg::DSS_BIAS_UP) ||
                     (next_state == dss_pkg::DSS_RUN); // R10 R14 R09
      PWM_ENABLE  <= (next_state == dss_pkg::DSS_RUN); // R11 R09
      SS1_START   <= next_ss1 & supply_ok; // R09
      SS2_START   <= next_ss2 & supply_ok; // R09
      if (!running) begin
        RATIO_SS <= ratio_now; // R05
      end else if (!ratio_now) begin
        RATIO_SS <= 1'b0;
      end
      SW1_PULSE   <= tick1 & next_ss1 & supply_ok; // R08 R09
      SW2_PULSE   <= tick2 & next_ss2 & supply_ok; // R08 R09
      MODE_VALID  <= mode_set;
    end
  end
endmodule

/* File: core/dss_pkg.sv */
// Constants and types shared by the dual output startup sequencer
// Summary of operation
// R01: Order-select high: output 1 waits for output 2
// R02: Master enable dropped: both outputs off at once
// R03: Order-select low: output 2 waits for output 1
// R04: System holds slave enable low in sequential modes
// R05: Floating, enables together: both start ratiometrically together
// R06: Floating, separate enables: each output runs independently
// R07: Oscillator runs at twice channel switching rate
// R08: Oscillator cycles alternate between the two channels
// R09: Below lockout: everything off, all switches off; RATIO_SS and MODE_VALID are not forced low
// R10: Lockout clear and any enable: bias regulator on
// R11: Bias good: modulation enabled, soft start begins
// R12: Slave start waits fixed delay after master regulation
// R13: Order-select sampled at power-on and kept
// R14: Both enables high: shutdown, bias regulator off
// R15: Supply, bias, regulation flags sampled on oscillator clock
package dss_pkg;

  // Clock period in ns and slave release delay in us
  localparam int CLK_PERIOD_NS  = 25;
  localparam int SLAVE_DELAY_US = 400;
  localparam int SLAVE_DELAY_CYC =
    (SLAVE_DELAY_US * 1000) / CLK_PERIOD_NS;

  // Clock cycles per oscillator cycle (one channel slot); each channel switches at half the oscillator rate
  localparam int OSC_DIV_DEFAULT = 67;

  // Three-state order-select encoding: {tied_high, tied_low}
  localparam logic [1:0] SEL_FLOAT = 2'h0;
  localparam logic [1:0] SEL_LOW   = 2'h1;
  localparam logic [1:0] SEL_HIGH  = 2'h2;

  typedef enum logic [1:0] {
    DSS_MODE_INDEP,
    DSS_MODE_1_FIRST,
    DSS_MODE_2_FIRST
  } dss_mode_type;

  typedef enum logic [2:0] {
    DSS_OFF,
    DSS_SHUTDOWN,
    DSS_BIAS_UP,
    DSS_RUN
  } dss_state_type;

endpackage

/* File: core/dss_phase.sv */
// Oscillator divider and alternating channel slot generator
`timescale 1ns/100ps
module dss_phase #(
  parameter int DIV = dss_pkg::OSC_DIV_DEFAULT
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      tick1,
  output logic      tick2
);
  initial begin
    if (DIV < 1) $error("DIV must be at least 1");
  end

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt;
  logic          slot;
  wire           osc_edge = (cnt == CW'(DIV - 1));

  // One oscillator cycle goes to each channel in turn
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt   <= '0;
      slot  <= 1'b0;
      tick1 <= 1'b0;
      tick2 <= 1'b0;
    end else if (!run) begin
      cnt   <= '0;
      slot  <= 1'b0;
      tick1 <= 1'b0;
      tick2 <= 1'b0;
    end else begin
      cnt   <= osc_edge ? '0 : cnt + 1'b1; // R07
      if (osc_edge) begin
        slot <= ~slot; // R08
      end
      tick1 <= osc_edge & ~slot; // R08
      tick2 <= osc_edge & slot;  // R08
    end
  end
endmodule

/* File: tb/dss_partner.sv */
// System side model: bias rail and output rails coming up after start
`timescale 1ns/100ps
module dss_partner (
  input  wire logic CLK,
  input  wire logic slow,
  input  wire logic BIAS_REG_ON,
  input  wire logic SS1_START,
  input  wire logic SS2_START,
  output logic      BIAS_GOOD,
  output logic      OUT1_IN_REG,
  output logic      OUT2_IN_REG
);
  logic [3:0] cb = 4'h0;
  logic [3:0] c1 = 4'h0;
  logic [3:0] c2 = 4'h0;
  wire  [3:0] lag = slow ? 4'hC : 4'h2;
  // Rails ramp for a while, but collapse at once when their source stops
  always @(posedge CLK) begin
    cb <= BIAS_REG_ON ? cb + {3'h0, cb != lag} : 4'h0;
    c1 <= SS1_START ? c1 + {3'h0, c1 != lag} : 4'h0;
    c2 <= SS2_START ? c2 + {3'h0, c2 != lag} : 4'h0;
  end
  assign BIAS_GOOD   = cb == lag;
  assign OUT1_IN_REG = c1 == lag;
  assign OUT2_IN_REG = c2 == lag;
endmodule

/* File: tb/dss_properties.sv */
// Concurrent checks on the startup sequencer ports
`timescale 1ns/100ps
module dss_properties #(
  parameter int DELAY_CYC = 20,
  parameter int OSC_DIV   = 3
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SUPPLY_GOOD,
  input wire logic OUT1_IN_REG,
  input wire logic OUT2_IN_REG,
  input wire logic OUTPUT1_ENABLE_N,
  input wire logic OUTPUT2_ENABLE_N,
  input wire logic ORDER_SEL_HIGH,
  input wire logic ORDER_SEL_LOW,
  input wire logic BIAS_REG_ON,
  input wire logic PWM_ENABLE,
  input wire logic SS1_START,
  input wire logic SS2_START,
  input wire logic SW1_PULSE,
  input wire logic SW2_PULSE,
  input wire logic MODE_VALID
);
  logic [15:0] cnt1;
  logic [15:0] cnt2;
  logic [15:0] gap1;
  logic        seen1;
  logic        mh;
  logic        ml;
  wire         any_on = !(OUTPUT1_ENABLE_N && OUTPUT2_ENABLE_N);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Mode is captured once, as the design does, so later pin moves are moot
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      {cnt1, cnt2, gap1, seen1, mh, ml} <= '0;
    end else begin
      cnt1 <= OUT1_IN_REG ? cnt1 + 16'h1 : 16'h0;
      cnt2 <= OUT2_IN_REG ? cnt2 + 16'h1 : 16'h0;
      // Channel 1 slots are the reference; a lone master has them only when output 1 is the master
      gap1  <= SW1_PULSE ? 16'h1 : gap1 + 16'h1;
      seen1 <= SS1_START && (SW1_PULSE || seen1);
      if ($rose(MODE_VALID)) begin
        mh <= ORDER_SEL_HIGH && !ORDER_SEL_LOW;
        ml <= ORDER_SEL_LOW && !ORDER_SEL_HIGH;
      end
    end
  end
  a_lockout_all_off: assert property (!SUPPLY_GOOD [*6] |->
    !(BIAS_REG_ON || PWM_ENABLE || SS1_START || SS2_START))
    else $error("outputs active in lockout");
  a_shutdown_bias_off: assert property (
    (OUTPUT1_ENABLE_N && OUTPUT2_ENABLE_N) [*6] |-> !BIAS_REG_ON)
    else $error("bias on with both enables high");
  a_bias_on_cause: assert property (
    $rose(BIAS_REG_ON) |-> SUPPLY_GOOD && any_on)
    else $error("bias on without supply and enable");
  a_pwm_needs_bias: assert property (
    PWM_ENABLE |-> BIAS_REG_ON && MODE_VALID)
    else $error("modulation without bias");
  a_osc_slot_gap: assert property (
    SW1_PULSE && seen1 |-> gap1 == 2 * OSC_DIV)
    else $error("switch slot spacing wrong");
  a_slots_alternate: assert property (
    SW2_PULSE && seen1 |-> gap1 == OSC_DIV && !SW1_PULSE)
    else $error("switch slots not alternating");
  a_master_drop_both: assert property (
    (mh && $fell(SS2_START)) || (ml && $fell(SS1_START)) |->
    !SS1_START && !SS2_START)
    else $error("outputs not dropped together");
  a_slave_after_two: assert property (
    mh && $rose(SS1_START) |-> SS2_START && cnt2 >= DELAY_CYC)
    else $error("output 1 started early");
  a_slave_after_one: assert property (
    ml && $rose(SS2_START) |-> SS1_START && cnt1 >= DELAY_CYC)
    else $error("output 2 started early");
endmodule
bind dss_top dss_properties #(.DELAY_CYC(DELAY_CYC), .OSC_DIV(OSC_DIV))
  dss_properties_i (.CLK(CLK), .RST_N(RST_N), .SUPPLY_GOOD(SUPPLY_GOOD),
  .OUT1_IN_REG(OUT1_IN_REG), .OUT2_IN_REG(OUT2_IN_REG),
  .OUTPUT1_ENABLE_N(OUTPUT1_ENABLE_N), .OUTPUT2_ENABLE_N(OUTPUT2_ENABLE_N),
  .ORDER_SEL_HIGH(ORDER_SEL_HIGH), .ORDER_SEL_LOW(ORDER_SEL_LOW),
  .BIAS_REG_ON(BIAS_REG_ON), .PWM_ENABLE(PWM_ENABLE),
  .SS1_START(SS1_START), .SS2_START(SS2_START), .SW1_PULSE(SW1_PULSE),
  .SW2_PULSE(SW2_PULSE), .MODE_VALID(MODE_VALID));

/* File: tb/testbench.sv */
// Self-checking bench for the startup sequencer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("Error %s expected %0h seen %0h", nm, e, g); \
  end end
module testbench;
  logic CLK, RST_N, SUPPLY_GOOD, ORDER_SEL_HIGH, ORDER_SEL_LOW, slow;
  logic OUTPUT1_ENABLE_N, OUTPUT2_ENABLE_N;
  wire  BIAS_GOOD, OUT1_IN_REG, OUT2_IN_REG, BIAS_REG_ON, PWM_ENABLE;
  wire  SS1_START, SS2_START, RATIO_SS, SW1_PULSE, SW2_PULSE, MODE_VALID;
  int   checked = 0;
  int   n_mismatch = 0;
  int   n1, n2;
  // {sel high, sel low, en1_n, en2_n, ss1, ss2, ratio, bias}
  localparam logic [7:0] ROWS [6] = '{8'h0F, 8'h19, 8'h25, 8'h30,
    8'h8D, 8'h4D};
  dss_top #(.DELAY_CYC(20), .OSC_DIV(3)) dss_top_i (.CLK(CLK),
    .RST_N(RST_N), .SUPPLY_GOOD(SUPPLY_GOOD), .BIAS_GOOD(BIAS_GOOD),
    .OUT1_IN_REG(OUT1_IN_REG), .OUT2_IN_REG(OUT2_IN_REG),
    .OUTPUT1_ENABLE_N(OUTPUT1_ENABLE_N), .OUTPUT2_ENABLE_N(OUTPUT2_ENABLE_N),
    .ORDER_SEL_HIGH(ORDER_SEL_HIGH), .ORDER_SEL_LOW(ORDER_SEL_LOW),
    .BIAS_REG_ON(BIAS_REG_ON), .PWM_ENABLE(PWM_ENABLE),
    .SS1_START(SS1_START), .SS2_START(SS2_START), .RATIO_SS(RATIO_SS),
    .SW1_PULSE(SW1_PULSE), .SW2_PULSE(SW2_PULSE), .MODE_VALID(MODE_VALID));
  dss_partner dss_partner_i (.CLK(CLK), .slow(slow),
    .BIAS_REG_ON(BIAS_REG_ON), .SS1_START(SS1_START),
    .SS2_START(SS2_START), .BIAS_GOOD(BIAS_GOOD),
    .OUT1_IN_REG(OUT1_IN_REG), .OUT2_IN_REG(OUT2_IN_REG));
  always #12.5 CLK = ~CLK;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Reset mid-run, then power up with a fresh select and enable setting
  task automatic start(input logic [3:0] cfg, input logic s);
    RST_N <= 1'b0;
    SUPPLY_GOOD <= 1'b0;
    slow <= s;
    {ORDER_SEL_HIGH, ORDER_SEL_LOW, OUTPUT1_ENABLE_N, OUTPUT2_ENABLE_N} <= cfg;
    repeat (5) @(posedge CLK);
    `CHK("reset outputs", 2'h0, {BIAS_REG_ON, MODE_VALID})
    RST_N <= 1'b1;
    SUPPLY_GOOD <= 1'b1;
    repeat (100) @(posedge CLK);
  endtask
  initial begin
    CLK = 1'b0;
    RST_N = 1'b0;
    SUPPLY_GOOD = 1'b0;
    {ORDER_SEL_HIGH, ORDER_SEL_LOW, slow} = 3'h0;
    {OUTPUT1_ENABLE_N, OUTPUT2_ENABLE_N} = 2'h3;
    for (int i = 0; i < 6; i++) begin
      start(ROWS[i][7:4], i[0]);
      `CHK("run state", {ROWS[i][3:0], ROWS[i][0], 1'b1}, {SS1_START, SS2_START, RATIO_SS, BIAS_REG_ON, PWM_ENABLE, MODE_VALID})
    end
    // Select moved and slave enable raised after latching: both ignored
    ORDER_SEL_HIGH <= 1'b1;
    ORDER_SEL_LOW <= 1'b0;
    OUTPUT2_ENABLE_N <= 1'b1;
    repeat (10) @(posedge CLK);
    `CHK("slave kept", 2'h3, {SS1_START, SS2_START})
    OUTPUT1_ENABLE_N <= 1'b1;
    repeat (6) @(posedge CLK);
    `CHK("master drop", 2'h0, {SS1_START, SS2_START})
    OUTPUT1_ENABLE_N <= 1'b0;
    repeat (100) @(posedge CLK);
    `CHK("restart", 2'h3, {SS1_START, SS2_START})
    n1 = 0;
    n2 = 0;
    // Sampled mid-cycle, away from the edge that launches the pulses
    repeat (12) begin
      @(negedge CLK);
      n1 += SW1_PULSE;
      n2 += SW2_PULSE;
    end
    `CHK("slot count", 8'h22, {n1[3:0], n2[3:0]})
    @(posedge CLK);
    SUPPLY_GOOD <= 1'b0;
    repeat (6) @(posedge CLK);
    `CHK("lockout", 6'h0, {BIAS_REG_ON, PWM_ENABLE, SS1_START, SS2_START, SW1_PULSE, SW2_PULSE})
    wrap_up;
  end
  // A hang runs well past the roughly 770 cycles the sequence needs
  initial begin
    repeat (3000) @(posedge CLK);
    n_mismatch++;
    wrap_up;
  end
endmodule
